// *** dimon_pkg.sv ***
package dimon_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 25;
	localparam int DIMON_TICK_NS     = 10_000_000;
	localparam int DIMON_TICK_CYCLES = DIMON_TICK_NS / CLK_PERIOD_NS;
	localparam logic [15:0] DELAY_MIN_TICKS = 16'h0002;
	localparam logic [15:0] DELAY_MAX_TICKS = 16'hFDE8;
	localparam logic [15:0] DELAY_DEF_TICKS = 16'h0014;

	// ----------------------------------------------------------------
	// Channel layout
	// ----------------------------------------------------------------
	localparam int DIMON_NUM_CH  = 12;
	localparam int BREAKER_CH    = 7;
	localparam int NUM_FLAGS     = 32;
	localparam int CFG_BITS      = 28;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_QUAL     = 12'h000;
	localparam logic [11:0] OFS_ALARM    = 12'h004;
	localparam logic [11:0] OFS_ACK      = 12'h008;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
	localparam logic [11:0] OFS_CFG_BASE = 12'h100;
	localparam int          ACK_BIT      = 0;

	typedef enum logic [2:0] {
		CLS_A, CLS_B, CLS_C, CLS_D, CLS_E, CLS_F, CLS_CTRL
	} dimon_class_type;

	typedef enum logic [1:0] {
		EN_ALWAYS, EN_LOCK, EN_FLAG
	} dimon_en_type;

	typedef struct packed {
		logic [4:0]      flag_sel;
		dimon_en_type    en_mode;
		logic            self_ack;
		dimon_class_type cls;
		logic            nc;
		logic [15:0]     delay;
	} dimon_cfg_type;

	localparam dimon_cfg_type CFG_RESET = '{
		flag_sel: 5'h00, en_mode: EN_ALWAYS, self_ack: 1'b0,
		cls: CLS_B, nc: 1'b0, delay: DELAY_DEF_TICKS
	};

	// Out-of-range delays are pulled into the legal window
	function automatic logic [15:0] clamp_delay(input logic [15:0] d);
		if (d < DELAY_MIN_TICKS) begin
			return DELAY_MIN_TICKS;
		end else if (d > DELAY_MAX_TICKS) begin
			return DELAY_MAX_TICKS;
		end
		return d;
	endfunction

endpackage

// *** dimon_qual.sv ***
`timescale 1ns/1ps
module dimon_qual
	import dimon_pkg::*;
#(
	parameter int TICK_CYCLES = DIMON_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// Channel input and settings
	input  wire logic        raw_i,
	input  wire logic        nc_i,
	input  wire logic        enable_i,
	input  wire logic [15:0] delay_i,
	// Delayed, qualified state
	output logic             qual_o
);

	localparam int CW = $clog2(TICK_CYCLES);

	initial begin
		if (TICK_CYCLES < 2) begin
			$error("TICK_CYCLES must be at least 2");
		end
	end

	logic          active;
	logic [15:0]   dly;
	logic [CW-1:0] cyc_r;
	logic [15:0]   ticks_r;
	logic [15:0]   ticks_nxt;
	logic          wrap;

	// ----------------------------------------------------------------
	// Qualification
	// ----------------------------------------------------------------
	// Open wire reads de-energized, so N.C. sees it as active
	assign active    = (raw_i ^ nc_i) & enable_i;
	assign dly       = clamp_delay(delay_i);
	assign wrap      = (cyc_r == CW'(TICK_CYCLES - 1));
	assign ticks_nxt = (wrap && ticks_r != dly) ? ticks_r + 16'h0001 : ticks_r;

	// Own prescaler per channel so the delay is exact, not tick-phase dependent
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !active) begin
			cyc_r   <= '0;
			ticks_r <= '0;
		end else if (ticks_r != dly) begin
			cyc_r   <= wrap ? '0 : cyc_r + CW'(1);
			ticks_r <= ticks_nxt;
		end
	end

	// Any dropout drops the output in the same edge as the restart
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !active) begin
			qual_o <= 1'b0;
		end else begin
			qual_o <= (ticks_nxt == dly);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_dropout_clears: assert property (!active |=> !qual_o && ticks_r == 16'h0000)
		else $error("qualified state survived a dropout");
	a_full_delay: assert property ($rose(qual_o) |-> ticks_r == dly && $past(active))
		else $error("qualified before the full delay");
	a_no_count_idle: assert property (!enable_i |=> ticks_r == 16'h0000 && cyc_r == '0)
		else $error("delay counter ran while monitoring was off");

endmodule

// *** dimon_top.sv ***
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Each channel has a delay from 0.02 s to 650.00 s, 0.20 s by default, for alarm or control use.
// - A channel reacts only after its qualified input stays active unbroken for the whole delay.
// - The state offered to the logic equations is the delayed, qualified one, not the raw input; channel 8 offers its raw input one clock late.
// - Normally open counts an energized input as active; normally closed a de-energized one.
// - In normally closed mode a broken wire reads as active, so wire breaks are detected.
// - Each channel has a class: A and B warn (B default), C to F shut down, or control only.
// - The assigned class is triggered whenever the qualified state becomes active.
// - A control-only channel gives just a control signal and writes no history record.
// - With self-acknowledge on, the alarm clears by itself once the fault is gone.
// - With self-acknowledge off (default) the alarm stays latched until a button or external ack.
// - A control-only channel always behaves as self-acknowledging.
// - With enable set to always the channel is evaluated continuously.
// - With enable set to monitoring lock the channel is evaluated only while the lock is false.
// - The enable may name one of 32 logic flags; the channel is evaluated only while it is true.
// - Channel 8 is the breaker position reply and takes none of the channel settings.
module dimon_top
	import dimon_pkg::*;
#(
	parameter int NUM_CH      = DIMON_NUM_CH,
	parameter int TICK_CYCLES = DIMON_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Field inputs and system conditions
	input  wire logic [NUM_CH-1:0] di_energized_i,
	input  wire logic              monitor_lock_i,
	input  wire logic [NUM_FLAGS-1:0] logic_flag_select_i,
	input  wire logic              ack_button_i,
	input  wire logic              ack_ext_i,
	// Channel results
	output logic      [NUM_CH-1:0] qualified_o,
	output logic      [NUM_CH-1:0] alarm_o,
	output logic      [NUM_CH-1:0] control_o,
	output logic      [NUM_CH-1:0] event_log_o,
	output logic                   warning_active_o,
	output logic                   shutdown_active_o,
	output logic                   breaker_reply_o,
	output logic                   irq_o
);

	initial begin
		if (NUM_CH <= BREAKER_CH || NUM_CH > 32) begin
			$error("NUM_CH must be 8 to 32");
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Index of a config word, or -1 when the address is not one
	function automatic int cfg_index(input logic [11:0] a);
		if (a >= OFS_CFG_BASE && a < OFS_CFG_BASE + 12'(4 * NUM_CH) && a[1:0] == 2'b00) begin
			return int'((a - OFS_CFG_BASE) >> 2);
		end
		return -1;
	endfunction

	// True for any register or config word; the rest answer with an error
	function automatic logic addr_mapped(input logic [11:0] a);
		if (a == OFS_QUAL || a == OFS_ALARM || a == OFS_ACK) begin
			return 1'b1;
		end else if (a == OFS_IRQ_STAT || a == OFS_IRQ_MASK) begin
			return 1'b1;
		end
		return cfg_index(a) >= 0;
	endfunction

	// Evaluation gate; a disabled channel reads as inactive and restarts its delay
	function automatic logic mon_enabled(input dimon_cfg_type c, input logic lock,
	                                     input logic [NUM_FLAGS-1:0] flags);
		case (c.en_mode)
			EN_ALWAYS: return 1'b1;
			EN_LOCK:   return !lock;
			EN_FLAG:   return flags[c.flag_sel];
			default:   return 1'b1;
		endcase
	endfunction

	dimon_cfg_type     cfg_r [NUM_CH];
	logic [NUM_CH-1:0] qual;
	logic [NUM_CH-1:0] qual_d_r;
	logic [NUM_CH-1:0] rise;
	logic [NUM_CH-1:0] is_ctrl;
	logic [NUM_CH-1:0] auto_ack;
	logic [NUM_CH-1:0] alarm_r;
	logic [NUM_CH-1:0] alarm_nxt;
	logic [NUM_CH-1:0] event_r;
	logic [NUM_CH-1:0] irq_stat_r;
	logic [NUM_CH-1:0] irq_mask_r;
	logic [NUM_CH-1:0] warn_v;
	logic [NUM_CH-1:0] shut_v;
	logic              wr_acc;
	logic              rd_setup;
	logic              ack_any;
	logic [31:0]       rdata_r;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero-wait slave: read data is fetched in the setup cycle
	assign wr_acc    = psel_i & penable_i & pwrite_i;
	assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~addr_mapped(paddr_i);
	assign prdata_o  = rdata_r;
	assign ack_any   = ack_button_i | ack_ext_i
	                 | (wr_acc && paddr_i == OFS_ACK && pwdata_i[ACK_BIT]);

	// Read mux, registered
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			if (paddr_i == OFS_QUAL) begin
				rdata_r <= 32'(qual);
			end else if (paddr_i == OFS_ALARM) begin
				rdata_r <= 32'(alarm_r);
			end else if (paddr_i == OFS_IRQ_STAT) begin
				rdata_r <= 32'(irq_stat_r);
			end else if (paddr_i == OFS_IRQ_MASK) begin
				rdata_r <= 32'(irq_mask_r);
			end else if (cfg_index(paddr_i) >= 0) begin
				rdata_r <= 32'(cfg_r[cfg_index(paddr_i)]);
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel configuration
	// ----------------------------------------------------------------
	// The breaker reply channel keeps its reset image; writes are dropped
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				cfg_r[i] <= CFG_RESET;
			end
		end else if (wr_acc && cfg_index(paddr_i) >= 0 && cfg_index(paddr_i) != BREAKER_CH) begin
			cfg_r[cfg_index(paddr_i)] <= dimon_cfg_type'(pwdata_i[CFG_BITS-1:0]);
		end
	end

	// ----------------------------------------------------------------
	// Qualifiers
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		if (g == BREAKER_CH) begin : g_brk
			logic brk_r;

			// Plain position reply, no delay, no polarity
			always_ff @(posedge clk_i) begin
				if (!reset_n_i) begin
					brk_r <= 1'b0;
				end else begin
					brk_r <= di_energized_i[g];
				end
			end
			// Own flop keeps the shared vector free of mixed drivers
			assign qual[g] = brk_r;
		end else begin : g_cfg
			dimon_qual #(
				.TICK_CYCLES (TICK_CYCLES)
			) u_qual (
				.clk_i     (clk_i),
				.reset_n_i (reset_n_i),
				.raw_i     (di_energized_i[g]),
				.nc_i      (cfg_r[g].nc),
				.enable_i  (mon_enabled(cfg_r[g], monitor_lock_i, logic_flag_select_i)),
				.delay_i   (cfg_r[g].delay),
				.qual_o    (qual[g])
			);
		end
	end

	// ----------------------------------------------------------------
	// Alarm handling
	// ----------------------------------------------------------------
	// Class decode; the breaker channel counts as control so it never alarms
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			is_ctrl[i]  = (cfg_r[i].cls == CLS_CTRL) || (i == BREAKER_CH);
			auto_ack[i] = cfg_r[i].self_ack | is_ctrl[i];
			warn_v[i]   = alarm_r[i] && cfg_r[i].cls inside {CLS_A, CLS_B};
			shut_v[i]   = alarm_r[i] && cfg_r[i].cls inside {CLS_C, CLS_D, CLS_E, CLS_F};
		end
	end

	assign rise = qual & ~qual_d_r;
	// Ack only releases a channel whose fault is gone; a new rise wins
	assign alarm_nxt = (rise & ~is_ctrl)
	                 | (alarm_r & ~(~qual & (auto_ack | {NUM_CH{ack_any}})));

	// Record pulse and latch share one edge, so the history matches the alarm
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			qual_d_r <= '0;
			alarm_r  <= '0;
			event_r  <= '0;
		end else begin
			qual_d_r <= qual;
			alarm_r  <= alarm_nxt;
			event_r  <= rise & ~is_ctrl;
		end
	end

	// Only the breaker channel offers its raw terminal level to the equations, one clock late
	assign qualified_o       = qual;
	assign control_o         = qual & is_ctrl;
	assign alarm_o           = alarm_r;
	assign event_log_o       = event_r;
	assign warning_active_o  = |warn_v;
	assign shutdown_active_o = |shut_v;
	assign breaker_reply_o   = qual[BREAKER_CH];

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// New alarm events are sticky; write one clears, a same-cycle event wins
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
		end else begin
			if (wr_acc && paddr_i == OFS_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r & ~pwdata_i[NUM_CH-1:0]) | (rise & ~is_ctrl);
			end else begin
				irq_stat_r <= irq_stat_r | (rise & ~is_ctrl);
			end
			if (wr_acc && paddr_i == OFS_IRQ_MASK) begin
				irq_mask_r <= pwdata_i[NUM_CH-1:0];
			end
		end
	end

	// Level output; software clears the cause, not the line
	assign irq_o = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_fault_gone(int c);
		alarm_r[c] && !qual[c];
	endsequence

	sequence s_acked(int c);
		s_fault_gone(c) ##0 ack_any;
	endsequence

	sequence s_new_fault(int c);
		$rose(qual[c]) && !is_ctrl[c];
	endsequence

	// Per-channel alarm checks; the breaker channel rides along as control
	for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
		a_class_trigger: assert property (s_new_fault(g) |=> alarm_r[g])
			else $error("alarm not raised on qualified rise");
		a_log_on_rise: assert property (s_new_fault(g) |=> event_r[g])
			else $error("history record missing for a new alarm");
		a_latched_hold: assert property (s_fault_gone(g) ##0 !auto_ack[g] ##0 !ack_any
			|=> alarm_r[g])
			else $error("latched alarm dropped without ack");
		a_ack_release: assert property (s_acked(g) |=> !alarm_r[g])
			else $error("acknowledged alarm did not clear");
		a_self_release: assert property (s_fault_gone(g) ##0 auto_ack[g] |=> !alarm_r[g])
			else $error("self-acknowledged alarm did not clear");
		a_ctrl_no_log: assert property (is_ctrl[g] |-> ##1 !event_r[g] && !alarm_r[g])
			else $error("control-only channel logged an event");
		a_warn_class: assert property (alarm_r[g] && cfg_r[g].cls inside {CLS_A, CLS_B}
			|-> warning_active_o)
			else $error("warning alarm not shown as warning");
		a_shut_class: assert property (alarm_r[g]
			&& cfg_r[g].cls inside {CLS_C, CLS_D, CLS_E, CLS_F} |-> shutdown_active_o)
			else $error("shutdown alarm not shown as shutdown");
		a_lock_stops: assert property (g != BREAKER_CH && cfg_r[g].en_mode == EN_LOCK
			&& monitor_lock_i |=> !qual[g])
			else $error("channel evaluated under monitoring lock");
		a_flag_gate: assert property (g != BREAKER_CH && cfg_r[g].en_mode == EN_FLAG
			&& !logic_flag_select_i[cfg_r[g].flag_sel] |=> !qual[g])
			else $error("channel evaluated with its flag false");
	end

	a_breaker_fixed: assert property (cfg_r[BREAKER_CH] == CFG_RESET
		&& qual[BREAKER_CH] == $past(di_energized_i[BREAKER_CH]))
		else $error("breaker channel took a setting or lagged");
	a_irq_level: assert property ((irq_o == |(irq_stat_r & irq_mask_r))
		and ($rose(irq_o) |-> $past(|(rise & ~is_ctrl))
		|| $past(wr_acc && paddr_i == OFS_IRQ_MASK)))
		else $error("interrupt not tied to a new event");

endmodule

// *** dimon_contact.sv ***
`timescale 1ns/1ps
module dimon_contact #(
	parameter int N = 12
) (
	// Contact state chosen by the bench
	input  wire logic [N-1:0] operated_i,
	input  wire logic [N-1:0] wired_nc_i,
	input  wire logic [N-1:0] broken_i,
	// Terminal level seen by the block
	output logic      [N-1:0] energized_o
);
	// A broken wire carries no potential, whatever the contact type
	assign energized_o = ~broken_i & (operated_i ^ wired_nc_i);
endmodule

// *** test_dimon_top.sv ***
`timescale 1ns/1ps
module test_dimon_top;
	import dimon_pkg::*;
	localparam int TC = 4;
	logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, flags;
	logic        lock, ack_b, ack_x, warn, shut, brk, irq_o;
	logic [11:0] oper, wnc, broken, energ, qual, alarm, ctrl, evlog;
	int          mismatches, check_count;

	// ----------------------------------------------------------------
	// Block, field contacts and clock
	// ----------------------------------------------------------------
	dimon_top #(.NUM_CH(12), .TICK_CYCLES(TC)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.di_energized_i(energ), .monitor_lock_i(lock), .logic_flag_select_i(flags),
		.ack_button_i(ack_b), .ack_ext_i(ack_x), .qualified_o(qual), .alarm_o(alarm),
		.control_o(ctrl), .event_log_o(evlog), .warning_active_o(warn),
		.shutdown_active_o(shut), .breaker_reply_o(brk), .irq_o(irq_o));
	dimon_contact #(.N(12)) field (.operated_i(oper), .wired_nc_i(wnc), .broken_i(broken),
		.energized_o(energ));
	// Free-running 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Reporting and compares
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic timeout();
		mismatches++;
		$display("unexpected at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask
	task automatic chk_num(input int got, input int exp, input string m);
		check_count++;
		if (got != exp) begin
			mismatches++;
			$display("unexpected at %0t: %s took %0d", $time, m, got);
		end
	endtask

	// ----------------------------------------------------------------
	// APB master and helpers
	// ----------------------------------------------------------------
	// Request held until pready is seen at an edge; data taken at that edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		for (int k = 0; k <= 16; k++) begin
			@(posedge clk_i);
			if (pready_o === 1'b1) break;
			if (k == 16) timeout();
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk_word(r, x, "read data");
		chk_bit(e, xe, "read error");
	endtask
	function automatic logic [31:0] cfg(input int d, nc, cl, sa, en, fl);
		return {4'h0, fl[4:0], en[1:0], sa[0], cl[2:0], nc[0], d[15:0]};
	endfunction
	// Counts edges until the channel qualifies; caller changed inputs at this edge
	task automatic wait_qual(input int ch, input int exp);
		int n;
		n = 0;
		while (qual[ch] !== 1'b1) begin
			@(posedge clk_i);
			#1;
			n++;
			if (n > 400) timeout();
		end
		chk_num(n, exp, "qualify delay");
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_chk(OFS_CFG_BASE, 32'h0002_0014, 1'b0);
		rd_chk(OFS_IRQ_MASK, 32'h0, 1'b0);
		rd_chk(12'h020, 32'h0, 1'b1);
	endtask
	// Latched warning, ack while still faulted, interrupt mask and clear
	task automatic t_latch();
		wr(OFS_CFG_BASE, cfg(2, 0, 1, 0, 0, 0));
		@(posedge clk_i);
		oper[0] <= 1'b1;
		wait_qual(0, 2 * TC);
		tick(1);
		chk_bit(alarm[0], 1'b1, "alarm set");
		chk_bit(evlog[0], 1'b1, "history record");
		chk_bit(warn, 1'b1, "warning class");
		tick(1);
		chk_bit(evlog[0], 1'b0, "record pulse");
		rd_chk(OFS_QUAL, 32'h1, 1'b0);
		ack_b <= 1'b1;
		@(posedge clk_i);
		ack_b <= 1'b0;
		oper[0] <= 1'b0;
		tick(3);
		chk_bit(alarm[0], 1'b1, "latched");
		@(posedge clk_i);
		ack_x <= 1'b1;
		@(posedge clk_i);
		ack_x <= 1'b0;
		tick(1);
		chk_bit(alarm[0], 1'b0, "external ack");
		chk_bit(irq_o, 1'b0, "masked irq");
		wr(OFS_IRQ_MASK, 32'h1);
		tick(1);
		chk_bit(irq_o, 1'b1, "unmasked irq");
		wr(OFS_IRQ_STAT, 32'h1);
		tick(1);
		chk_bit(irq_o, 1'b0, "irq cleared");
	endtask
	// One-cycle dropout restarts the count; register ack releases
	task automatic t_dropout();
		@(posedge clk_i);
		oper[0] <= 1'b1;
		repeat (6) @(posedge clk_i);
		oper[0] <= 1'b0;
		@(posedge clk_i);
		oper[0] <= 1'b1;
		wait_qual(0, 2 * TC);
		@(posedge clk_i);
		oper[0] <= 1'b0;
		tick(2);
		wr(OFS_ACK, 32'h1);
		tick(1);
		chk_bit(alarm[0], 1'b0, "register ack");
	endtask
	// Normally closed, wire break, delay below range, self-ack shutdown
	task automatic t_nc();
		@(posedge clk_i);
		wnc[1] <= 1'b1;
		wr(OFS_CFG_BASE + 12'h004, cfg(0, 1, 2, 1, 0, 0));
		tick(4);
		chk_bit(qual[1], 1'b0, "closed loop idle");
		@(posedge clk_i);
		broken[1] <= 1'b1;
		wait_qual(1, 2 * TC);
		tick(1);
		chk_bit(shut, 1'b1, "shutdown class");
		@(posedge clk_i);
		broken[1] <= 1'b0;
		tick(3);
		chk_bit(alarm[1], 1'b0, "self ack");
	endtask
	task automatic t_ctrl();
		wr(OFS_CFG_BASE + 12'h008, cfg(2, 0, 6, 0, 0, 0));
		@(posedge clk_i);
		oper[2] <= 1'b1;
		wait_qual(2, 2 * TC);
		tick(1);
		chk_bit(ctrl[2], 1'b1, "control out");
		chk_bit(evlog[2] | alarm[2], 1'b0, "no record");
		@(posedge clk_i);
		oper[2] <= 1'b0;
		tick(3);
		chk_bit(ctrl[2], 1'b0, "control release");
	endtask
	// Monitoring lock and flag gating
	task automatic t_enable();
		wr(OFS_CFG_BASE + 12'h00C, cfg(2, 0, 1, 0, 1, 0));
		wr(OFS_CFG_BASE + 12'h010, cfg(2, 0, 1, 0, 2, 5));
		lock <= 1'b1;
		oper[4:3] <= 2'b11;
		flags[4] <= 1'b1;
		tick(20);
		chk_bit(qual[3], 1'b0, "locked");
		chk_bit(qual[4], 1'b0, "flag false");
		@(posedge clk_i);
		lock <= 1'b0;
		wait_qual(3, 2 * TC);
		@(posedge clk_i);
		flags[5] <= 1'b1;
		wait_qual(4, 2 * TC);
		@(posedge clk_i);
		lock <= 1'b1;
		tick(2);
		chk_bit(qual[3], 1'b0, "lock suspends");
	endtask
	task automatic t_breaker();
		wr(OFS_CFG_BASE + 12'h01C, cfg(2, 1, 2, 1, 1, 3));
		rd_chk(OFS_CFG_BASE + 12'h01C, 32'h0002_0014, 1'b0);
		@(posedge clk_i);
		oper[7] <= 1'b1;
		tick(2);
		chk_bit(brk, 1'b1, "breaker reply");
		chk_bit(alarm[7] | evlog[7], 1'b0, "breaker no alarm");
	endtask

	// Main sequence
	initial begin
		{psel_i, penable_i, pwrite_i, lock, ack_b, ack_x} = '0;
		{paddr_i, pwdata_i, flags, oper, wnc, broken} = '0;
		reset_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_latch();
		t_dropout();
		t_nc();
		t_ctrl();
		t_enable();
		t_breaker();
		wrap_up();
	end
endmodule
